// file: rtl/pidar_top.sv
`timescale 1ns/1ps
module pidar_top #(
	parameter logic [21:0]  MAKER_UNIQUE_IDENTIFIER   = 22'h2a5a5a, // arbitrary value
	parameter logic [5:0]   MODEL = 6'h15,      // arbitrary value
	parameter logic [3:0]   REV   = 4'h3        // arbitrary value
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic        HREADY,
	input  wire logic [31:0] HWDATA,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic      [15:0] ADV_ACTIVE,
	output logic             ADV_RESTART
);

	// ----------------------------------------------------------------
	// address phase capture
	// ----------------------------------------------------------------
	logic        wr_pend;
	logic [5:0]  wr_idx;
	logic        pending;
	logic [15:0] adv_q;
	logic [15:0] adv_next;
	logic [15:0] live_q;
	logic [15:0] live_next;

	wire         addr_ok = HSEL & HREADY & HTRANS[1];
	wire [5:0]   addr_idx = HADDR[7:2];
	wire         take_wr = addr_ok & HWRITE & (HSIZE == pidar_pkg::HSIZE_WORD);
	wire         take_rd = addr_ok & ~HWRITE;

	// only word writes are latched; narrower writes fall through silently
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wr_pend <= 1'b0;
			wr_idx  <= 6'h00;
		end else if (CE) begin
			wr_pend <= take_wr;
			wr_idx  <= addr_idx;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// identifier indices are deliberately absent: such writes do nothing [R5]
	wire wr_adv      = wr_pend & (wr_idx == pidar_pkg::ADV_IDX);
	wire wr_ctrl     = wr_pend & (wr_idx == pidar_pkg::CTRL_IDX);
	wire restart_req = wr_ctrl & HWDATA[pidar_pkg::RESTART_BIT];

	// ----------------------------------------------------------------
	// advertisement storage and live copy
	// ----------------------------------------------------------------
	// software copy; reserved bits and selector stay fixed [R6] [R7] [R9]
	pidar_hold_reg #(
		.W     (16),
		.RESET (pidar_pkg::ADV_RESET),
		.MASK  (pidar_pkg::ADV_WR_MASK)
	) u_adv (
		.clk    (REF_CLK),
		.rst    (RST),
		.ce     (CE),
		.load   (wr_adv),
		.din    (HWDATA[15:0]),
		.q      (adv_q),
		.next_q (adv_next)
	);

	// link copy only moves on restart, so edits never leak early [R8]
	pidar_hold_reg #(
		.W     (16),
		.RESET (pidar_pkg::ADV_RESET),
		.MASK  (16'hffff)
	) u_live (
		.clk    (REF_CLK),
		.rst    (RST),
		.ce     (CE),
		.load   (restart_req),
		.din    (adv_q),
		.q      (live_q),
		.next_q (live_next)
	);

	// pending flag: set wins, though both cannot come in one data phase
	wire next_pending = wr_adv | (pending & ~restart_req); // [R8]

	// link-facing outputs and pending flag
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pending     <= 1'b0;
			ADV_ACTIVE  <= pidar_pkg::ADV_RESET;
			ADV_RESTART <= 1'b0;
		end else if (CE) begin
			pending     <= next_pending;
			ADV_ACTIVE  <= live_next;
			ADV_RESTART <= restart_req; // [R8]
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// built from next values so a read right behind a write sees it
	wire [15:0] id_high = MAKER_UNIQUE_IDENTIFIER[21:6]; // [R1] [R2]
	wire [15:0] id_low  = {MAKER_UNIQUE_IDENTIFIER[5:0], MODEL, REV}; // [R2] [R3] [R4]
	wire [31:0] live_word = {15'h0000, next_pending, live_next};
	logic [31:0] rd_mux;

	// restart bit self-clears, so the control word always reads zero
	always_comb begin
		if (addr_idx == pidar_pkg::ID_HIGH_IDX) begin
			rd_mux = {16'h0000, id_high};
		end else if (addr_idx == pidar_pkg::ID_LOW_IDX) begin
			rd_mux = {16'h0000, id_low};
		end else if (addr_idx == pidar_pkg::ADV_IDX) begin
			rd_mux = {16'h0000, adv_next}; // [R9]
		end else if (addr_idx == pidar_pkg::ADV_LIVE_IDX) begin
			rd_mux = live_word;
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// zero wait states: ready and OKAY are constant after reset
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else if (CE) begin
			HRDATA    <= take_rd ? rd_mux : 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// identifier reads come straight from the parameters, one cycle after the address
	id_high_read_a: assert property ( // [R1]
		(CE && take_rd && addr_idx == pidar_pkg::ID_HIGH_IDX)
		|=> HRDATA == {16'h0000, MAKER_UNIQUE_IDENTIFIER[21:6]})
		else $error("high identifier read wrong");
	id_low_oui_a: assert property ( // [R2]
		(CE && take_rd && addr_idx == pidar_pkg::ID_LOW_IDX)
		|=> HRDATA[15:10] == MAKER_UNIQUE_IDENTIFIER[5:0] && HRDATA[31:16] == 16'h0000)
		else $error("low maker bits wrong");
	model_field_a: assert property ( // [R3]
		(CE && take_rd && addr_idx == pidar_pkg::ID_LOW_IDX)
		|=> HRDATA[9:4] == MODEL)
		else $error("model number wrong");
	rev_field_a: assert property ( // [R4]
		(CE && take_rd && addr_idx == pidar_pkg::ID_LOW_IDX)
		|=> HRDATA[3:0] == REV)
		else $error("revision number wrong");
	id_write_ignored_a: assert property ( // [R5]
		(CE && wr_pend &&
		(wr_idx == pidar_pkg::ID_HIGH_IDX || wr_idx == pidar_pkg::ID_LOW_IDX))
		|=> $stable(adv_q) && $stable(pending) && $stable(ADV_ACTIVE))
		else $error("identifier write had an effect");

	// ----------------------------------------------------------------
	// advertisement assertions
	// ----------------------------------------------------------------
	// link copy is watched apart from the software copy, only restart joins them
	adv_reset_a: assert property ( // [R6]
		$fell(RST)
		|-> adv_q == pidar_pkg::ADV_RESET && ADV_ACTIVE == pidar_pkg::ADV_RESET)
		else $error("advertisement reset value wrong");
	adv_mask_a: assert property ( // [R9]
		(adv_q & ~pidar_pkg::ADV_WR_MASK)
		== (pidar_pkg::ADV_RESET & ~pidar_pkg::ADV_WR_MASK))
		else $error("fixed advertisement bits moved");
	tech_write_a: assert property ( // [R7]
		(CE && wr_adv)
		|=> adv_q[8:5] == $past(HWDATA[8:5]) && pending)
		else $error("technology field not written");
	live_hold_a: assert property ( // [R8]
		!(CE && restart_req) |=> $stable(ADV_ACTIVE))
		else $error("live advertisement moved without restart");
	restart_copy_a: assert property ( // [R8]
		(CE && restart_req)
		|=> ADV_ACTIVE == $past(adv_q) && ADV_RESTART && !pending)
		else $error("restart did not copy advertisement");
	// back to back restarts stretch the pulse, so only a quiet cycle must drop it
	restart_only_a: assert property ( // [R8]
		(CE && !restart_req) |=> !ADV_RESTART)
		else $error("restart pulse without restart write");
	pending_hold_a: assert property ( // [R8]
		(CE && !wr_adv && !restart_req) |=> $stable(pending))
		else $error("pending flag moved by itself");
	reserved_zero_a: assert property ( // [R9]
		(CE && take_rd && addr_idx == pidar_pkg::ADV_IDX)
		|=> (HRDATA & ~{16'h0000, pidar_pkg::ADV_WR_MASK | pidar_pkg::ADV_FIXED})
		== 32'h0000_0000)
		else $error("reserved advertisement bits set");

	// ----------------------------------------------------------------
	// bus and enable assertions
	// ----------------------------------------------------------------
	// no wait states and no error response are ever given
	ready_okay_a: assert property (HREADYOUT && !HRESP)
		else $error("slave stalled or gave an error");
	idle_rdata_a: assert property ((CE && !take_rd) |=> HRDATA == 32'h0000_0000)
		else $error("read data left standing");
	freeze_hold_a: assert property ( // [R8]
		!CE |=> $stable(adv_q) && $stable(ADV_ACTIVE) && $stable(HRDATA)
		&& $stable(ADV_RESTART))
		else $error("state moved while enable low");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------
	restart_seen_c: cover property (CE && wr_adv ##[1:20] CE && restart_req);
	adv_readback_c: cover property (CE && wr_adv ##2 CE && take_rd &&
		addr_idx == pidar_pkg::ADV_IDX);
	id_read_c: cover property (CE && take_rd && addr_idx == pidar_pkg::ID_LOW_IDX);
	restart_pulse_c: cover property (ADV_RESTART ##1 !ADV_RESTART);
	frozen_access_c: cover property (!CE && addr_ok);

endmodule // pidar_top

// file: inc/pidar_pkg.sv
// How it works
// R1: the two identifier registers together carry one 32-bit maker, model and revision value.
// R2: maker identifier bits 21..6 sit in the high identifier, bits 5..0 in low identifier 15..10.
// R3: low identifier bits 9..4 hold the fixed model number.
// R4: low identifier bits 3..0 hold the fixed revision number.
// R5: both identifier registers are read-only and writes leave them and all else untouched.
// R6: the advertisement register is read/write and comes out of reset at 0x01e1.
// R7: advertisement bits 8..5 are the technology ability field that software may rewrite.
// R8: a new advertisement reaches the link only when the restart bit of the control register is set.
// R9: reserved advertisement bits read as zero and ignore writes.
package pidar_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0]  CTRL_IDX     = 6'h00;
	localparam logic [5:0]  ID_HIGH_IDX  = 6'h02;
	localparam logic [5:0]  ID_LOW_IDX   = 6'h03;
	localparam logic [5:0]  ADV_IDX      = 6'h04;
	localparam logic [5:0]  ADV_LIVE_IDX = 6'h10;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned RESTART_BIT  = 9;
	localparam int unsigned PENDING_BIT  = 16;
	localparam int unsigned OUI_LO_POS   = 10;
	localparam int unsigned MODEL_POS    = 4;
	localparam int unsigned REV_POS      = 0;
	localparam int unsigned TECH_LSB     = 5;
	localparam int unsigned TECH_MSB     = 8;
	localparam logic [15:0] ADV_RESET    = 16'h01e1;
	localparam logic [15:0] ADV_WR_MASK  = 16'h21e0;
	localparam logic [15:0] ADV_FIXED    = 16'h0001;

	// ----------------------------------------------------------------
	// bus encodings
	// ----------------------------------------------------------------
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;

endpackage

// file: rtl/pidar_hold_reg.sv
`timescale 1ns/1ps
module pidar_hold_reg #(
	parameter int unsigned        W     = 16,
	parameter logic [W-1:0]       RESET = '0,
	parameter logic [W-1:0]       MASK  = '1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             load,
	input  wire logic [W-1:0]     din,
	output logic      [W-1:0]     q,
	output logic      [W-1:0]     next_q
);

	// masked load: bits outside the mask keep their reset value forever
	assign next_q = load ? ((din & MASK) | (RESET & ~MASK)) : q;

	// storage
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET;
		end else if (ce) begin
			q <= next_q;
		end
	end

endmodule // pidar_hold_reg

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [21:0] MAKER_UNIQUE_IDENTIFIER   = 22'h1b3c4d; // arbitrary value
	localparam logic [5:0]  MODEL = 6'h2e;      // arbitrary value
	localparam logic [3:0]  REV   = 4'h9;       // arbitrary value
	logic        REF_CLK, RST, CE, HWRITE, HRESP, HREADYOUT, ADV_RESTART;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [15:0] ADV_ACTIVE;
	int          err_count, checks;

	// ----------------------------------------------------------------
	// device and clock; bus ready loops back from the only slave
	// ----------------------------------------------------------------
	pidar_top #(.MAKER_UNIQUE_IDENTIFIER(MAKER_UNIQUE_IDENTIFIER), .MODEL(MODEL), .REV(REV)) pidar_top_i (
		.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .HSEL(1'b1), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT),
		.HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.ADV_ACTIVE(ADV_ACTIVE), .ADV_RESTART(ADV_RESTART));
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for hready sampled high at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (HREADYOUT !== 1'b1) begin
			err_count++;
			summarize();
		end
	endtask
	// one single word transfer; read data taken at the data phase end edge
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		@(posedge REF_CLK);
		HADDR  <= a;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HSIZE  <= 3'h2;
		wait_rdy();
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		rd = HRDATA;
		chk({31'h0, HRESP}, 32'h0); // okay response always
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		xfer(32'h10, 1'b0, 32'h0);
		chk(rd, 32'h0000_01e1);
		chk({16'h0, ADV_ACTIVE}, 32'h0000_01e1);
		xfer(32'h20, 1'b0, 32'h0);
		chk(rd, 32'h0); // unmapped place reads zero
		$display("test_reset done");
	endtask
	// identifiers read back, then survive writes of all ones
	task automatic test_ident();
		for (int k = 0; k < 2; k++) begin
			xfer(32'h08, 1'b0, 32'h0);
			chk(rd, {16'h0, MAKER_UNIQUE_IDENTIFIER[21:6]});
			xfer(32'h0c, 1'b0, 32'h0);
			chk(rd, {16'h0, MAKER_UNIQUE_IDENTIFIER[5:0], MODEL, REV});
			xfer(32'h08, 1'b1, 32'hffff_ffff);
			xfer(32'h0c, 1'b1, 32'hffff_ffff);
		end
		$display("test_ident done");
	endtask
	// rewrite advertisement; link keeps old value until restart
	task automatic test_advert();
		xfer(32'h10, 1'b1, 32'hffff_ffff);
		xfer(32'h10, 1'b0, 32'h0);
		chk(rd, 32'h0000_21e1);
		xfer(32'h10, 1'b1, 32'h0000_0000);
		xfer(32'h10, 1'b1, 32'h0000_0140);
		xfer(32'h10, 1'b0, 32'h0);
		chk(rd, 32'h0000_0141);
		xfer(32'h40, 1'b0, 32'h0);
		chk(rd, 32'h0001_01e1);
		chk({16'h0, ADV_ACTIVE}, 32'h0000_01e1);
		xfer(32'h00, 1'b1, 32'h0000_0200);
		@(posedge REF_CLK);
		chk({31'h0, ADV_RESTART}, 32'h1);
		chk({16'h0, ADV_ACTIVE}, 32'h0000_0141);
		@(posedge REF_CLK);
		chk({31'h0, ADV_RESTART}, 32'h0);
		xfer(32'h40, 1'b0, 32'h0);
		chk(rd, 32'h0000_0141);
		$display("test_advert done");
	endtask
	// traffic with enable low is lost; a mid-run reset restores the default
	task automatic test_freeze();
		@(posedge REF_CLK);
		CE <= 1'b0;
		xfer(32'h10, 1'b1, 32'h0000_0020);
		xfer(32'h00, 1'b1, 32'h0000_0200);
		CE <= 1'b1;
		chk({31'h0, ADV_RESTART}, 32'h0);
		xfer(32'h10, 1'b0, 32'h0);
		chk(rd, 32'h0000_0141);
		xfer(32'h40, 1'b0, 32'h0);
		chk(rd, 32'h0000_0141);
		@(posedge REF_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		xfer(32'h10, 1'b0, 32'h0);
		chk(rd, 32'h0000_01e1);
		chk({16'h0, ADV_ACTIVE}, 32'h0000_01e1);
		$display("test_freeze done");
	endtask

	initial begin
		err_count = 0;
		checks    = 0;
		RST       = 1'b1;
		CE        = 1'b1;
		HADDR     = 32'h0;
		HTRANS    = 2'h0;
		HWRITE    = 1'b0;
		HSIZE     = 3'h2;
		HWDATA    = 32'h0;
		repeat (4) @(posedge REF_CLK);
		RST <= 1'b0;
		test_reset();
		test_ident();
		test_advert();
		test_freeze();
		summarize();
	end
endmodule // testbench
